// ===== logic/exc_sequencer.v
// exception and interrupt sequencing unit with avalon-mm register slave
// Contract
// - after set-interrupt-enable, block external interrupts until next instruction ends
// - v86 mode, privilege below 3: flags-pop or interrupt-return traps, no stack access
// - such a trap never fires the stack-top data breakpoint, nor at handler entry
// - fault-address and feature-control registers are kept across breakpoints and interrupts
// - a page fault loads its linear address into the fault-address register
// - in protected mode the feature-control register gates v86, io bp, pse, mce
// - leaving system management restores neither register; changes made inside persist
// - 64-bit compare-exchange compares upper:lower accumulators with 8-byte memory value
// - register destination raises invalid-opcode, halts instruction, runs its handler
// - invalid-opcode uses descriptor table vector 6
// - only locked register-destination form checks entry 6 page write, faults if denied
// - that page fault is serviced before invalid-opcode, so no bus lock forms
`timescale 1ns/1ps
`include "exc_seq_map.vh"

module exc_sequencer (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        ext_intr_pin,
  output wire        intr_take,
  input  wire        instr_retire,
  input  wire        instr_is_sti,
  input  wire        instr_is_pop_flags_instr,
  input  wire        instr_is_interrupt_return_instr,
  input  wire        instr_is_compare_exchange_64_instr,
  input  wire        dest_is_reg,
  input  wire        lock_prefix,
  input  wire        v86_mode,
  input  wire [1:0]  io_privilege_level,
  input  wire        stack_bp_match,
  output wire        stack_access_inhibit,
  output wire        data_bp_fire,
  input  wire        page_fault,
  input  wire [31:0] page_fault_addr,
  input  wire        smm_active,
  input  wire [31:0] upper_accumulator,
  input  wire [31:0] lower_accumulator,
  input  wire [63:0] mem_qword,
  output wire        cmpxchg_equal,
  input  wire [31:0] idt_base,
  output wire        idt_check_req,
  output wire [31:0] idt_check_addr,
  input  wire        idt_check_done,
  input  wire        idt_write_ok,
  input  wire        locked_op_start,
  input  wire        locked_op_end,
  output wire        bus_lock,
  output wire        exc_valid,
  output wire [7:0]  exc_vector,
  output wire [31:0] fault_address_reg,
  output wire [31:0] feature_control_reg,
  output wire        v86_ext_en,
  output wire        io_bp_en,
  output wire        page_size_ext_en,
  output wire        machine_check_en
);

  localparam [3:0] S_IDLE   = 4'b0001;
  localparam [3:0] S_IDTCHK = 4'b0010;
  localparam [3:0] S_UNLOCK = 4'b0100;
  localparam [3:0] S_DISP   = 4'b1000;

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [7:0]  vec_q;
  reg  [7:0]  vec_d;
  reg         exc_valid_q;
  reg  [7:0]  exc_vector_q;
  reg         bus_lock_q;
  reg         shadow_q;
  reg         sup_q;
  reg         dbg_fire_q;
  reg         intr_take_q;
  reg         cmp_eq_q;
  reg  [31:0] ctrl_q;
  reg  [`ST_WIDTH-1:0] status_q;
  reg  [`ST_WIDTH-1:0] mask_q;
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         intr_meta_q;
  reg         intr_sync_q;
  reg         pf_load;
  reg  [31:0] pf_addr;

  wire        bus_req;
  wire        wr_en;
  wire        sti_now;
  wire        gp_trap;
  wire        ud_form;
  wire        locked_ud;
  wire        recognize;
  wire [31:0] entry6_addr;
  wire [`ST_WIDTH-1:0] st_set;
  wire [`ST_WIDTH-1:0] st_clr;

  // ---------------- avalon slave: one wait cycle per access
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_en           = avs_write & ack_q;
  assign avs_readdata    = rdata_q;

  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      `OFS_CTRL:         rdata_d = ctrl_q;
      `OFS_FAULT_ADDR:   rdata_d = fault_address_reg;
      `OFS_FEATURE_CTRL: rdata_d = feature_control_reg;
      `OFS_STATUS:       rdata_d = {{(32-`ST_WIDTH){1'b0}}, status_q};
      `OFS_MASK:         rdata_d = {{(32-`ST_WIDTH){1'b0}}, mask_q};
      `OFS_STATE:        rdata_d = {24'h00_0000, shadow_q, sup_q, bus_lock_q, 1'b0, state_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= bus_req & ~ack_q;
      // read data is sampled while waiting so it stands at the accepting edge
      if (avs_read & ~ack_q)
        rdata_q <= rdata_d;
    end
  end

  // ---------------- external interrupt pin synchroniser
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      intr_meta_q <= 1'b0;
      intr_sync_q <= 1'b0;
    end else if (ce) begin
      intr_meta_q <= ext_intr_pin;
      intr_sync_q <= intr_meta_q;
    end
  end

  // ---------------- decode of the retiring instruction
  assign sti_now   = instr_retire & instr_is_sti;
  assign gp_trap   = instr_retire & (instr_is_pop_flags_instr | instr_is_interrupt_return_instr) & v86_mode
                     & (io_privilege_level != `IO_PRIVILEGE_LEVEL_USER);
  assign ud_form   = instr_retire & instr_is_compare_exchange_64_instr & dest_is_reg;
  assign locked_ud = ud_form & lock_prefix;
  assign entry6_addr = idt_base + ({24'h00_0000, `VEC_INVALID_OP} * `IDT_ENTRY_BYTES);

  // the shadow survives management-mode entry so no early window opens there
  assign recognize = ctrl_q[`CTRL_INTR_EN] & intr_sync_q & ~shadow_q & ~sti_now
                     & ~smm_active & (state_q == S_IDLE) & ~instr_retire;

  // ---------------- sequencing state machine
  always @* begin
    state_d = state_q;
    vec_d   = vec_q;
    pf_load = 1'b0;
    pf_addr = page_fault_addr;
    case (state_q)
      S_IDLE: begin
        if (locked_ud) begin
          state_d = S_IDTCHK;
        end else if (ud_form) begin
          vec_d   = `VEC_INVALID_OP;
          state_d = S_UNLOCK;
        end else if (gp_trap) begin
          vec_d   = `VEC_GEN_PROT;
          state_d = S_UNLOCK;
        end else if (page_fault) begin
          vec_d   = `VEC_PAGE_FAULT;
          pf_load = 1'b1;
          state_d = S_UNLOCK;
        end
      end
      S_IDTCHK: begin
        if (idt_check_done) begin
          if (idt_write_ok) begin
            vec_d = `VEC_INVALID_OP;
          end else begin
            // page fault goes first; the lock is never taken on this path
            vec_d   = `VEC_PAGE_FAULT;
            pf_load = 1'b1;
            pf_addr = entry6_addr;
          end
          state_d = S_UNLOCK;
        end
      end
      S_UNLOCK: state_d = S_DISP;
      S_DISP:   state_d = S_IDLE;
      default:  state_d = S_IDLE;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= S_IDLE;
      vec_q        <= 8'h00;
      exc_valid_q  <= 1'b0;
      exc_vector_q <= 8'h00;
    end else if (ce) begin
      state_q     <= state_d;
      vec_q       <= vec_d;
      exc_valid_q <= (state_q == S_DISP);
      if (state_q == S_DISP)
        exc_vector_q <= vec_q;
    end
  end

  // bus lock: held by a valid locked op, dropped before any exception handler fetch; an interrupt take does not drop it
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      bus_lock_q <= 1'b0;
    else if (ce) begin
      if (state_q == S_UNLOCK || locked_op_end)
        bus_lock_q <= 1'b0;
      else if (locked_op_start && state_q == S_IDLE && !locked_ud)
        bus_lock_q <= 1'b1;
    end
  end

  // interrupt shadow and breakpoint suppression
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_q    <= 1'b0;
      sup_q       <= 1'b0;
      dbg_fire_q  <= 1'b0;
      intr_take_q <= 1'b0;
    end else if (ce) begin
      if (instr_retire)
        shadow_q <= instr_is_sti;
      // stays up until the handler's first instruction has retired
      if (gp_trap && state_q == S_IDLE)
        sup_q <= 1'b1;
      else if (instr_retire && state_q == S_IDLE)
        sup_q <= 1'b0;
      dbg_fire_q  <= stack_bp_match & ~sup_q & ~gp_trap;
      intr_take_q <= recognize;
    end
  end

  assign stack_access_inhibit = sup_q | gp_trap;

  // 64-bit compare of the accumulator pair against memory
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      cmp_eq_q <= 1'b0;
    else if (ce && instr_is_compare_exchange_64_instr && !dest_is_reg)
      cmp_eq_q <= ({upper_accumulator, lower_accumulator} == mem_qword);
  end

  // ---------------- control, status and mask
  assign st_set[`ST_GP]     = (state_q == S_DISP) && (vec_q == `VEC_GEN_PROT);
  assign st_set[`ST_UD]     = (state_q == S_DISP) && (vec_q == `VEC_INVALID_OP);
  assign st_set[`ST_PF]     = (state_q == S_DISP) && (vec_q == `VEC_PAGE_FAULT);
  assign st_set[`ST_DBG]    = dbg_fire_q;
  assign st_set[`ST_INTR]   = intr_take_q;
  assign st_set[`ST_UNLOCK] = (state_q == S_UNLOCK) && bus_lock_q;
  assign st_clr = (wr_en && avs_address == `OFS_STATUS && avs_byteenable[0])
                  ? avs_writedata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q   <= `CTRL_RESET;
      status_q <= {`ST_WIDTH{1'b0}};
      mask_q   <= `MASK_RESET;
    end else if (ce) begin
      // a hardware set in the same cycle as a clear keeps the bit
      status_q <= (status_q & ~st_clr) | st_set;
      if (wr_en && avs_address == `OFS_MASK && avs_byteenable[0])
        mask_q <= avs_writedata[`ST_WIDTH-1:0];
      if (sti_now)
        ctrl_q[`CTRL_INTR_EN] <= 1'b1;
      // cleared on recognition itself so intr_take stays a one-cycle pulse
      else if (recognize)
        ctrl_q[`CTRL_INTR_EN] <= 1'b0;
      else if (wr_en && avs_address == `OFS_CTRL && avs_byteenable[0])
        ctrl_q[`CTRL_INTR_EN] <= avs_writedata[`CTRL_INTR_EN];
      if (wr_en && avs_address == `OFS_CTRL && avs_byteenable[0])
        ctrl_q[`CTRL_PROT_MODE] <= avs_writedata[`CTRL_PROT_MODE];
    end
  end

  fault_ctrl_regs u_regs (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .ce                  (ce),
    .fault_load          (pf_load),
    .fault_linear_addr   (pf_addr),
    .fault_wr            (wr_en && avs_address == `OFS_FAULT_ADDR),
    .feature_wr          (wr_en && avs_address == `OFS_FEATURE_CTRL),
    .wr_data             (avs_writedata),
    .wr_be               (avs_byteenable),
    .fault_address_reg   (fault_address_reg),
    .feature_control_reg (feature_control_reg)
  );

  // feature bits only act in protected mode
  assign v86_ext_en       = ctrl_q[`CTRL_PROT_MODE] & feature_control_reg[`FEAT_V86_EXT];
  assign io_bp_en         = ctrl_q[`CTRL_PROT_MODE] & feature_control_reg[`FEAT_IO_BP];
  assign page_size_ext_en = ctrl_q[`CTRL_PROT_MODE] & feature_control_reg[`FEAT_PSE];
  assign machine_check_en = ctrl_q[`CTRL_PROT_MODE] & feature_control_reg[`FEAT_MCE];

  assign irq            = |(status_q & mask_q);
  assign intr_take      = intr_take_q;
  assign data_bp_fire   = dbg_fire_q;
  assign cmpxchg_equal  = cmp_eq_q;
  assign idt_check_req  = (state_q == S_IDTCHK);
  assign idt_check_addr = entry6_addr;
  assign bus_lock       = bus_lock_q;
  assign exc_valid      = exc_valid_q;
  assign exc_vector     = exc_vector_q;

endmodule // exc_sequencer

// ===== logic/exc_seq_map.vh
// register offsets, field positions, reset values and vectors of the exception sequencer
`ifndef EXC_SEQ_MAP_VH
`define EXC_SEQ_MAP_VH

// avalon byte offsets, one 32-bit word each
`define OFS_CTRL          5'h00
`define OFS_FAULT_ADDR    5'h04
`define OFS_FEATURE_CTRL  5'h08
`define OFS_STATUS        5'h0C
`define OFS_MASK          5'h10
`define OFS_STATE         5'h14

// control register fields
`define CTRL_INTR_EN      0
`define CTRL_PROT_MODE    1
`define CTRL_RESET        32'h0000_0000

// feature control fields
`define FEAT_V86_EXT      0
`define FEAT_IO_BP        1
`define FEAT_PSE          2
`define FEAT_MCE          3
`define FEATURE_RESET     32'h0000_0000
`define FAULT_ADDR_RESET  32'h0000_0000

// status and mask fields
`define ST_GP             0
`define ST_UD             1
`define ST_PF             2
`define ST_DBG            3
`define ST_INTR           4
`define ST_UNLOCK         5
`define ST_WIDTH          6
`define MASK_RESET        6'h00

// exception vectors
`define VEC_INVALID_OP    8'h06
`define VEC_GEN_PROT      8'h0D
`define VEC_PAGE_FAULT    8'h0E

// descriptor table geometry and user i/o privilege level
`define IDT_ENTRY_BYTES   32'h0000_0008
`define IO_PRIVILEGE_LEVEL_USER         2'h3

`endif

// ===== logic/fault_ctrl_regs.v
// fault-address and feature-control registers with their load priorities
`timescale 1ns/1ps
`include "exc_seq_map.vh"

module fault_ctrl_regs (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        fault_load,
  input  wire [31:0] fault_linear_addr,
  input  wire        fault_wr,
  input  wire        feature_wr,
  input  wire [31:0] wr_data,
  input  wire [3:0]  wr_be,
  output wire [31:0] fault_address_reg,
  output wire [31:0] feature_control_reg
);

  reg  [31:0] fault_addr_q;
  reg  [31:0] feature_q;
  wire [31:0] be_mask;

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_be
      assign be_mask[8*b+7:8*b] = {8{wr_be[b]}};
    end
  endgenerate

  // no snapshot exists: values written inside system management persist after resume
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_addr_q <= `FAULT_ADDR_RESET;
      feature_q    <= `FEATURE_RESET;
    end else if (ce) begin
      // hardware fault wins over a software write in the same cycle
      if (fault_load)
        fault_addr_q <= fault_linear_addr;
      else if (fault_wr)
        fault_addr_q <= (fault_addr_q & ~be_mask) | (wr_data & be_mask);
      // interrupts and breakpoints never touch either register
      if (feature_wr)
        feature_q <= (feature_q & ~be_mask) | (wr_data & be_mask);
    end
  end

  assign fault_address_reg   = fault_addr_q;
  assign feature_control_reg = feature_q;

endmodule // fault_ctrl_regs

// ===== verification/exc_seq_monitor.sv
// port-level assertions for the exception sequencer
`timescale 1ns/1ps
module exc_seq_monitor (
  input logic        clock,
  input logic        sys_rst,
  input logic        instr_retire,
  input logic        instr_is_sti,
  input logic        instr_is_pop_flags_instr,
  input logic        instr_is_interrupt_return_instr,
  input logic        instr_is_compare_exchange_64_instr,
  input logic        dest_is_reg,
  input logic        lock_prefix,
  input logic        v86_mode,
  input logic [1:0]  io_privilege_level,
  input logic        stack_bp_match,
  input logic        stack_access_inhibit,
  input logic        data_bp_fire,
  input logic        intr_take,
  input logic        smm_active,
  input logic [31:0] upper_accumulator,
  input logic [31:0] lower_accumulator,
  input logic [63:0] mem_qword,
  input logic        cmpxchg_equal,
  input logic [31:0] idt_base,
  input logic        idt_check_req,
  input logic [31:0] idt_check_addr,
  input logic        idt_check_done,
  input logic        idt_write_ok,
  input logic        bus_lock,
  input logic        exc_valid,
  input logic [7:0]  exc_vector,
  input logic [31:0] fault_address_reg,
  input logic [31:0] feature_control_reg,
  input logic        v86_ext_en,
  input logic        io_bp_en,
  input logic        page_size_ext_en,
  input logic        machine_check_en
);
  logic shadow_q;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // mirrors the one-instruction window after set-interrupt-enable
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) shadow_q <= 1'b0;
    else if (instr_retire) shadow_q <= instr_is_sti;

  chk_trap_inhibit:
    assert property (instr_retire && (instr_is_pop_flags_instr || instr_is_interrupt_return_instr) && v86_mode
      && io_privilege_level != 2'h3 && !instr_is_compare_exchange_64_instr |-> stack_access_inhibit)
    else $error("trapping flags instruction did not inhibit stack access");
  chk_bp_blocked:
    assert property ($past(stack_access_inhibit) |-> !data_bp_fire)
    else $error("stack breakpoint fired during a trap");
  chk_bp_cause:
    assert property (data_bp_fire |-> $past(stack_bp_match))
    else $error("breakpoint fired without an address hit");
  chk_shadow_take:
    assert property (intr_take |-> !$past(instr_retire) && !$past(shadow_q) && !$past(smm_active))
    else $error("interrupt taken inside the blocking window");
  chk_feature_gate:
    assert property (({machine_check_en, page_size_ext_en, io_bp_en, v86_ext_en}
      & ~feature_control_reg[3:0]) == 4'h0)
    else $error("feature enable without its control bit");
  chk_idt_entry:
    assert property (idt_check_req |-> idt_check_addr == idt_base + 32'h0000_0030)
    else $error("descriptor check not aimed at entry 6");
  chk_pf_first:
    assert property (idt_check_req && idt_check_done && !idt_write_ok |=>
      fault_address_reg == $past(idt_check_addr) ##[1:3] exc_valid && exc_vector == 8'h0E)
    else $error("denied descriptor write not serviced as page fault");
  chk_ud_vector:
    assert property (instr_retire && instr_is_compare_exchange_64_instr && dest_is_reg && !lock_prefix
      |-> ##[2:4] exc_valid && exc_vector == 8'h06)
    else $error("register destination did not raise vector 6");
  chk_unlock_first:
    assert property (exc_valid |-> !bus_lock)
    else $error("bus still locked at handler dispatch");
  chk_cmp_equal:
    assert property (instr_retire && instr_is_compare_exchange_64_instr && !dest_is_reg |=> cmpxchg_equal
      == ($past({upper_accumulator, lower_accumulator}) == $past(mem_qword)))
    else $error("compare result wrong");
endmodule // exc_seq_monitor

// ===== verification/testbench.sv
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`include "exc_seq_map.vh"
module testbench;
  logic        clock = 0, sys_rst = 1, ce = 1, avs_read = 0, avs_write = 0, ext_intr_pin = 0;
  logic        instr_retire = 0, instr_is_sti = 0, instr_is_pop_flags_instr = 0, instr_is_interrupt_return_instr = 0;
  logic        instr_is_compare_exchange_64_instr = 0, dest_is_reg = 0, lock_prefix = 0, v86_mode = 0;
  logic        stack_bp_match = 0, page_fault = 0, smm_active = 0, locked_op_end = 0;
  logic        idt_check_done = 0, idt_write_ok = 0, locked_op_start = 0;
  logic [1:0]  io_privilege_level = 0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [4:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, page_fault_addr = 0, idt_base = 32'h0000_1000;
  logic [31:0] upper_accumulator = 32'h1234_5678, lower_accumulator = 32'h9ABC_DEF0, rv;
  logic [63:0] mem_qword = 0;
  logic [31:0] sv_fault, sv_feat;
  logic        avs_waitrequest, irq, intr_take, stack_access_inhibit, data_bp_fire, bus_lock;
  logic        cmpxchg_equal, idt_check_req, exc_valid, v86_ext_en, io_bp_en;
  logic        page_size_ext_en, machine_check_en;
  logic [7:0]  exc_vector;
  logic [31:0] avs_readdata, idt_check_addr, fault_address_reg, feature_control_reg;
  int          bad_count = 0, checked = 0, cyc = 0, i, n;
  // {sti,pop_flags_instr,interrupt_return_instr,cmpxchg,reg dest,lock}, v86, privilege, exception expected, vector
  logic [17:0] rows [5] = '{{6'h10, 1'b1, 2'h0, 1'b1, 8'h0D}, {6'h08, 1'b1, 2'h2, 1'b1, 8'h0D},
                           {6'h10, 1'b1, 2'h3, 1'b0, 8'h00}, {6'h08, 1'b0, 2'h0, 1'b0, 8'h00},
                           {6'h06, 1'b0, 2'h0, 1'b1, 8'h06}};

  exc_sequencer dut_u (.*);

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  // read data and waitrequest are sampled before this edge's updates land
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rv = avs_readdata;
    chk("waitrequest", avs_waitrequest, 0);
    avs_read <= 0;
    avs_write <= 0;
  endtask

  task automatic instr(logic [5:0] f, logic b);
    @(posedge clock);
    {instr_is_sti, instr_is_pop_flags_instr, instr_is_interrupt_return_instr, instr_is_compare_exchange_64_instr, dest_is_reg, lock_prefix} <= f;
    instr_retire <= 1;
    stack_bp_match <= b;
    @(posedge clock);
    instr_retire <= 0;
  endtask

  task automatic wexc(logic ev, logic [7:0] v);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (exc_valid !== 1'b1 && n < 8);
    chk("exc_valid", exc_valid, ev);
    if (ev) chk("exc_vector", exc_vector, v);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    chk("fault_address_reg", fault_address_reg, 0);
    chk("bus_lock", bus_lock, 0);
    for (i = 0; i < 5; i++) begin
      @(posedge clock);
      v86_mode <= rows[i][11];
      io_privilege_level <= rows[i][10:9];
      instr(rows[i][17:12], 0);
      wexc(rows[i][8], rows[i][7:0]);
    end
    bus(0, `OFS_STATUS, 0);
    chk("status", rv & 32'h3F, 32'h03);
    bus(1, `OFS_STATUS, 32'h3F);
    bus(0, 5'h18, 0);
    chk("unmapped", rv, 0);
    bus(1, `OFS_FEATURE_CTRL, 32'hA);
    chk("enables", {machine_check_en, page_size_ext_en, io_bp_en, v86_ext_en}, 0);
    bus(1, `OFS_CTRL, 32'h2);
    @(posedge clock);
    chk("enables", {machine_check_en, page_size_ext_en, io_bp_en, v86_ext_en}, 4'hA);
    smm_active <= 1;
    bus(1, `OFS_FAULT_ADDR, 32'h0000_ABCD);
    smm_active <= 0;
    repeat (3) @(posedge clock);
    chk("fault_address_reg", fault_address_reg, 32'h0000_ABCD);
    // management handler saves both, changes them, restores both before resuming
    smm_active <= 1;
    bus(0, `OFS_FAULT_ADDR, 0);
    sv_fault = rv;
    bus(0, `OFS_FEATURE_CTRL, 0);
    sv_feat = rv;
    bus(1, `OFS_FAULT_ADDR, 32'h0000_5555);
    bus(1, `OFS_FEATURE_CTRL, 32'h0000_0005);
    bus(1, `OFS_FAULT_ADDR, sv_fault);
    bus(1, `OFS_FEATURE_CTRL, sv_feat);
    smm_active <= 0;
    repeat (2) @(posedge clock);
    chk("restored fault", fault_address_reg, 32'h0000_ABCD);
    chk("restored feature", feature_control_reg, 32'hA);
    bus(1, `OFS_MASK, 32'h10);
    ext_intr_pin <= 1;
    instr(6'h20, 0);
    n = 0;
    repeat (8) @(posedge clock) n += intr_take;
    chk("early take", n, 0);
    instr(6'h00, 0);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (intr_take !== 1'b1 && n < 8);
    chk("intr_take", intr_take, 1);
    ext_intr_pin <= 0;
    @(posedge clock);
    chk("irq", irq, 1);
    bus(1, `OFS_MASK, 0);
    @(posedge clock);
    chk("irq masked", irq, 0);
    bus(1, `OFS_STATUS, 32'h10);
    bus(1, `OFS_MASK, 32'h10);
    @(posedge clock);
    chk("irq cleared", irq, 0);
    chk("fault_address_reg", fault_address_reg, 32'h0000_ABCD);
    chk("feature_control_reg", feature_control_reg, 32'hA);
    v86_mode <= 1;
    io_privilege_level <= 0;
    instr(6'h10, 1);
    n = 0;
    repeat (8) @(posedge clock) n += data_bp_fire;
    stack_bp_match <= 0;
    v86_mode <= 0;
    chk("trap breakpoint", n, 0);
    instr(6'h00, 0);
    @(posedge clock);
    stack_bp_match <= 1;
    @(posedge clock);
    stack_bp_match <= 0;
    @(posedge clock);
    chk("data_bp_fire", data_bp_fire, 1);
    @(posedge clock);
    page_fault <= 1;
    page_fault_addr <= 32'h0040_2000;
    @(posedge clock);
    page_fault <= 0;
    wexc(1, 8'h0E);
    chk("fault_address_reg", fault_address_reg, 32'h0040_2000);
    // denied write first, then granted: only the denied case reroutes via page fault
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      locked_op_start <= 1;
      @(posedge clock);
      locked_op_start <= 0;
      instr(6'h07, 0);
      @(posedge clock);
      chk("idt_check_req", idt_check_req, 1);
      chk("idt_check_addr", idt_check_addr, 32'h0000_1030);
      idt_check_done <= 1;
      idt_write_ok <= i[0];
      @(posedge clock);
      idt_check_done <= 0;
      wexc(1, i ? 8'h06 : 8'h0E);
      chk("bus_lock", bus_lock, 0);
    end
    chk("fault_address_reg", fault_address_reg, 32'h0000_1030);
    // clock enable low: a page fault offered meanwhile must not load anything
    ce <= 0;
    page_fault <= 1;
    page_fault_addr <= 32'h0000_7777;
    repeat (2) @(posedge clock);
    page_fault <= 0;
    ce <= 1;
    repeat (5) @(posedge clock);
    chk("frozen fault addr", fault_address_reg, 32'h0000_1030);
    for (i = 0; i < 2; i++) begin
      mem_qword <= {32'h1234_5678, 32'h9ABC_DEF0 ^ i};
      instr(6'h04, 0);
      @(posedge clock);
      chk("cmpxchg_equal", cmpxchg_equal, i == 0);
    end
    test_done;
  end
endmodule // testbench

bind exc_sequencer exc_seq_monitor mon_u (.*);
